// File: src/accel_output_interrupt_regs.sv
// Register bank for the Z output, self-test response, identification, interrupt sources and main control.
// Assumes a serial front end on core_clk delivering one-cycle read/write strobes per byte with an address,
// and holding read_burst_active for the whole of a multi-byte read. All inputs are on core_clk.
//
// Contract
// - Z low byte shows sample bits 5 to 2 in bits 7 to 4 (5 to 0 in bits 7 to 2 with range code 11, zero in 8-bit).
// - Z high byte shows sample bits 13 to 6.
// - Self-test response reads 0x55 unless a test is pending, then 0xaa.
// - Reading the response while it holds 0xaa restores 0x55.
// - A read-only identification byte identifies the supplier.
// - Source registers update on events and stay latched until release read, or for the ready bit a data read.
// - An unlatched mode lets results lapse without a release read.
// - Release read clears the whole primary source register.
// - Ready bit sets on new sample; clears on data read or release read.
// - Wake bit sets on motion interrupt; clears only on release read, or at pulse end in unlatched mode.
// - Axis register reports X-,X+,Y-,Y+,Z-,Z+ in bits 5..0; release clears.
// - Status bit 4 is ready OR wake; clears with release, or with data read while wake is clear.
// - Release read clears sources, drops latched pin, returns 0x00.
// - Control bit 7 selects standby (0) or operating (1).
// - Control bit 6 selects 8-bit low current or 12/14-bit resolution.
// - Control bit 5 lets sample ready raise the interrupt.
// - Control bits 4:3 select 2g, 4g, 8g, 8g.
// - Range code 11 gives 14-bit output in full resolution only.
// - Control bit 1 enables wake-up motion detection.
// - Outputs are two's complement, 14-bit, 12-bit or 8-bit valid.
// - Outputs refresh per sample and are frozen during a host read.
`timescale 1ns/1ns

module accel_output_interrupt_regs #(
  parameter int unsigned SAMPLE_W = 14,
  parameter logic [7:0]  ID_VALUE = 8'h5a  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                                      core_clk,
  input  wire logic                                      reset,
  // Register access from the serial front end
  input  wire logic [7:0]                                reg_addr,
  input  wire logic                                      reg_rd_stb,
  input  wire logic                                      reg_wr_stb,
  input  wire logic [7:0]                                reg_wdata,
  input  wire logic                                      read_burst_active,
  output logic      [7:0]                                reg_rdata,
  // Sensing core
  input  wire logic [SAMPLE_W-1:0]                       z_sample_in,
  input  wire logic                                      sample_strobe,
  input  wire logic                                      motion_strobe,
  input  wire logic [accel_regs_pkg::AXIS_BITS-1:0]      motion_axis,
  // Settings held in neighbouring control registers
  input  wire logic                                      comm_selftest_trigger,
  input  wire logic                                      irq_unlatched_mode,
  // Interrupt and control outputs
  output logic                                           irq_pin,
  output logic                                           operate_select,
  output logic                                           resolution_select,
  output logic                                           sample_ready_irq_enable,
  output logic      [1:0]                                range_select,
  output logic                                           motion_wake_enable
);
  import accel_regs_pkg::*;

  initial begin
    if (SAMPLE_W != 14) $error("SAMPLE_W must be 14");
    if (IRQ_PULSE_CYCLES >= (1 << PULSE_CNT_W)) $error("Pulse counter too narrow");
  end

  typedef struct packed {
    logic [7:0]             main_control;
    logic [7:0]             z_low;
    logic [7:0]             z_high;
    logic [SAMPLE_W-1:0]    held_sample;
    logic                   sample_pending;
    logic                   src_ready;
    logic                   src_wake;
    logic [AXIS_BITS-1:0]   axis;
    logic                   selftest_pending;
    logic [7:0]             rdata;
    logic                   irq_pin;
    irq_state_t             irq_state;
    logic [PULSE_CNT_W-1:0] pulse_count;
  } bank_state_t;

  bank_state_t s;
  bank_state_t next_s;

  // Formats a sample into {high, low} by resolution and range
  function automatic logic [15:0] format_sample(input logic [SAMPLE_W-1:0] smp,
                                                input logic wide, input logic [1:0] rng);
    logic [15:0] r;
    r = 16'h0000;
    if (!wide) begin
      r = {smp[13:6], READ_ZERO};
    end else if (rng == RANGE_WIDE_CODE) begin
      r = {smp[13:6], smp[5:0], 2'b00};
    end else begin
      r = {smp[13:6], smp[5:2], 4'h0};
    end
    return r;
  endfunction : format_sample

  logic       operating;
  logic       load_now;
  logic       rd_release;
  logic       rd_data;
  logic       wake_event;
  logic       new_irq;
  logic [15:0] formatted;

  always_comb begin
    next_s     = s;
    operating  = s.main_control[CTRL_OPERATE_BIT];
    rd_release = reg_rd_stb && (reg_addr == ADDR_RELEASE);
    rd_data    = reg_rd_stb && (reg_addr == ADDR_Z_HIGH);
    wake_event = motion_strobe && operating && s.main_control[CTRL_WAKE_EN_BIT];
    formatted  = format_sample(s.held_sample, s.main_control[CTRL_WIDTH_BIT],
                               s.main_control[CTRL_RANGE_HI:CTRL_RANGE_LO]);
    new_irq    = 1'b0;

    // Sample capture; outputs frozen while a read burst runs
    if (sample_strobe && operating) begin
      next_s.held_sample    = z_sample_in;
      next_s.sample_pending = 1'b1;
    end
    load_now = (s.sample_pending || (sample_strobe && operating)) && !read_burst_active;
    if (s.sample_pending && !read_burst_active) begin
      next_s.z_high         = formatted[15:8];
      next_s.z_low          = formatted[7:0];
      next_s.sample_pending = sample_strobe && operating;
    end

    // Ready flag: clear on data or release read, set wins
    if (rd_data || rd_release) begin
      next_s.src_ready = 1'b0;
    end
    if (s.sample_pending && !read_burst_active) begin
      next_s.src_ready = 1'b1;
      new_irq          = s.main_control[CTRL_IRQ_EN_BIT];
    end

    // Wake flag and axis report: release read here, pulse end in unlatched mode below, set wins
    if (rd_release) begin
      next_s.src_wake = 1'b0;
      next_s.axis     = '0;
    end
    if (wake_event) begin
      next_s.src_wake = 1'b1;
      next_s.axis     = next_s.axis | motion_axis;
      new_irq         = 1'b1;
    end

    // Self-test response
    if (reg_rd_stb && (reg_addr == ADDR_SELFTEST_RESP) && s.selftest_pending) begin
      next_s.selftest_pending = 1'b0;
    end
    if (comm_selftest_trigger) begin
      next_s.selftest_pending = 1'b1;
    end

    // Main control; only the operate bit is writable while operating
    if (reg_wr_stb && (reg_addr == ADDR_MAIN_CTRL)) begin
      if (operating) begin
        next_s.main_control = (s.main_control & ~CTRL_OPER_MASK) |
                              (reg_wdata & CTRL_OPER_MASK);
      end else begin
        next_s.main_control = reg_wdata & CTRL_WRITE_MASK;
      end
    end

    // Read data
    if (reg_rd_stb) begin
      unique case (reg_addr)
        ADDR_Z_LOW:         next_s.rdata = s.z_low;
        ADDR_Z_HIGH:        next_s.rdata = s.z_high;
        ADDR_SELFTEST_RESP: next_s.rdata = s.selftest_pending ? SELFTEST_ACTIVE : SELFTEST_IDLE;
        ADDR_ID:            next_s.rdata = ID_VALUE;
        ADDR_SRC_PRIMARY: begin
          next_s.rdata                = READ_ZERO;
          next_s.rdata[SRC_READY_BIT] = s.src_ready;
          next_s.rdata[SRC_WAKE_BIT]  = s.src_wake;
        end
        ADDR_SRC_AXIS:      next_s.rdata = {2'b00, s.axis};
        ADDR_STATUS: begin
          next_s.rdata                 = READ_ZERO;
          next_s.rdata[STATUS_IRQ_BIT] = s.src_ready || s.src_wake;
        end
        ADDR_RELEASE:       next_s.rdata = READ_ZERO;
        ADDR_MAIN_CTRL:     next_s.rdata = s.main_control;
        default:            next_s.rdata = READ_ZERO;
      endcase
    end

    // Interrupt pin: latched level or timed pulse
    unique case (s.irq_state)
      IRQ_IDLE: begin
        if (irq_unlatched_mode && new_irq) begin
          next_s.irq_state   = IRQ_PULSE;
          next_s.pulse_count = PULSE_CNT_W'(IRQ_PULSE_CYCLES - 1);
        end
      end
      IRQ_PULSE: begin
        if (s.pulse_count == '0) begin
          next_s.irq_state = IRQ_IDLE;
          if (!new_irq && !s.sample_pending) begin
            next_s.src_ready = 1'b0;
          end
          if (!wake_event) begin
            next_s.src_wake = 1'b0;
            next_s.axis     = '0;
          end
        end else begin
          next_s.pulse_count = s.pulse_count - 1'b1;
        end
      end
    endcase
    if (irq_unlatched_mode) begin
      next_s.irq_pin = (next_s.irq_state == IRQ_PULSE);
    end else begin
      next_s.irq_pin = (next_s.src_ready && s.main_control[CTRL_IRQ_EN_BIT]) || next_s.src_wake;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s              <= '0;
      s.main_control <= MAIN_CTRL_RESET;
      s.irq_state    <= IRQ_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata               = s.rdata;
  assign irq_pin                 = s.irq_pin;
  assign operate_select          = s.main_control[CTRL_OPERATE_BIT];
  assign resolution_select       = s.main_control[CTRL_WIDTH_BIT];
  assign sample_ready_irq_enable = s.main_control[CTRL_IRQ_EN_BIT];
  assign range_select            = s.main_control[CTRL_RANGE_HI:CTRL_RANGE_LO];
  assign motion_wake_enable      = s.main_control[CTRL_WAKE_EN_BIT];

  // Checks
  property p_hold_during_read;
    @(posedge core_clk) disable iff (reset)
    read_burst_active |=> $stable(s.z_high) && $stable(s.z_low);
  endproperty
  a_hold_during_read: assert property (p_hold_during_read) else $error("Output changed during read");

  property p_selftest_idle;
    @(posedge core_clk) disable iff (reset)
    reg_rd_stb && (reg_addr == ADDR_SELFTEST_RESP) && !s.selftest_pending |=> reg_rdata == SELFTEST_IDLE;
  endproperty
  a_selftest_idle: assert property (p_selftest_idle) else $error("Idle pattern wrong");

  property p_selftest_restore;
    @(posedge core_clk) disable iff (reset)
    reg_rd_stb && (reg_addr == ADDR_SELFTEST_RESP) && s.selftest_pending && !comm_selftest_trigger
      |=> (reg_rdata == SELFTEST_ACTIVE) && !s.selftest_pending;
  endproperty
  a_selftest_restore: assert property (p_selftest_restore) else $error("Pattern not restored");

  property p_release_clears;
    @(posedge core_clk) disable iff (reset)
    rd_release && !load_now && !wake_event |=> !s.src_ready && !s.src_wake && (s.axis == '0);
  endproperty
  a_release_clears: assert property (p_release_clears) else $error("Release left sources set");

  property p_release_pin;
    @(posedge core_clk) disable iff (reset)
    rd_release && !load_now && !wake_event && !irq_unlatched_mode |=> !irq_pin;
  endproperty
  a_release_pin: assert property (p_release_pin) else $error("Pin still active after release");

  property p_ready_set;
    @(posedge core_clk) disable iff (reset)
    s.sample_pending && !read_burst_active |=> s.src_ready;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("Ready flag not set");

  property p_wake_axis;
    @(posedge core_clk) disable iff (reset)
    wake_event |=> s.src_wake && ((s.axis & $past(motion_axis)) == $past(motion_axis));
  endproperty
  a_wake_axis: assert property (p_wake_axis) else $error("Motion not reported");

  property p_status_or;
    @(posedge core_clk) disable iff (reset)
    reg_rd_stb && (reg_addr == ADDR_STATUS) |=> reg_rdata[STATUS_IRQ_BIT] == $past(s.src_ready || s.src_wake);
  endproperty
  a_status_or: assert property (p_status_or) else $error("Status bit mismatch");

  property p_ctrl_locked;
    @(posedge core_clk) disable iff (reset)
    reg_wr_stb && (reg_addr == ADDR_MAIN_CTRL) && operating |=> s.main_control[6:0] == $past(s.main_control[6:0]);
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) else $error("Control changed while operating");

  property p_standby_no_wake;
    @(posedge core_clk) disable iff (reset)
    motion_strobe && !operating && !rd_release && (s.irq_state == IRQ_IDLE) |=> $stable(s.src_wake);
  endproperty
  a_standby_no_wake: assert property (p_standby_no_wake) else $error("Wake set in standby");

  c_selftest: cover property (@(posedge core_clk) disable iff (reset)
    comm_selftest_trigger ##[1:20] (reg_rd_stb && reg_addr == ADDR_SELFTEST_RESP));
  c_release: cover property (@(posedge core_clk) disable iff (reset) irq_pin ##[1:50] rd_release);
  c_pulse: cover property (@(posedge core_clk) disable iff (reset) s.irq_state == IRQ_PULSE ##1 s.irq_state == IRQ_IDLE);
  c_frozen: cover property (@(posedge core_clk) disable iff (reset) read_burst_active && sample_strobe && operating);

endmodule : accel_output_interrupt_regs

// File: include/accel_regs_pkg.sv
// Register map, field positions, reset values and timing for the accelerometer register bank.
// Assumes a single 25 MHz core clock shared with the serial front end that issues byte accesses.
package accel_regs_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_Z_LOW         = 8'h0a;
  localparam logic [7:0] ADDR_Z_HIGH        = 8'h0b;
  localparam logic [7:0] ADDR_SELFTEST_RESP = 8'h0c;
  localparam logic [7:0] ADDR_ID            = 8'h0f;
  localparam logic [7:0] ADDR_SRC_PRIMARY   = 8'h16;
  localparam logic [7:0] ADDR_SRC_AXIS      = 8'h17;
  localparam logic [7:0] ADDR_STATUS        = 8'h18;
  localparam logic [7:0] ADDR_RELEASE       = 8'h1a;
  localparam logic [7:0] ADDR_MAIN_CTRL     = 8'h1b;

  // Main control fields
  localparam int unsigned CTRL_OPERATE_BIT = 7;
  localparam int unsigned CTRL_WIDTH_BIT   = 6;
  localparam int unsigned CTRL_IRQ_EN_BIT  = 5;
  localparam int unsigned CTRL_RANGE_HI    = 4;
  localparam int unsigned CTRL_RANGE_LO    = 3;
  localparam int unsigned CTRL_WAKE_EN_BIT = 1;
  localparam logic [7:0]  CTRL_WRITE_MASK  = 8'hfa;
  localparam logic [7:0]  CTRL_OPER_MASK   = 8'h80;
  localparam logic [7:0]  MAIN_CTRL_RESET  = 8'h00;
  localparam logic [1:0]  RANGE_WIDE_CODE  = 2'h3;

  // Source and status fields
  localparam int unsigned SRC_READY_BIT  = 4;
  localparam int unsigned SRC_WAKE_BIT   = 1;
  localparam int unsigned STATUS_IRQ_BIT = 4;
  localparam int unsigned AXIS_BITS      = 6;

  // Self-test patterns and fixed read values
  localparam logic [7:0] SELFTEST_IDLE   = 8'h55;
  localparam logic [7:0] SELFTEST_ACTIVE = 8'haa;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // Pulse mode interrupt width
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned IRQ_PULSE_MIN_NS = 30000;
  localparam int unsigned IRQ_PULSE_CYCLES = (IRQ_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W      = 10;

  typedef enum logic [0:0] {
    IRQ_IDLE  = 1'b0,
    IRQ_PULSE = 1'b1
  } irq_state_t;

endpackage : accel_regs_pkg

// File: bench/host_model.sv
// Host-side model that issues byte register accesses to the register bank.
// Assumes the bank samples strobes on the rising edge of core_clk and answers one cycle later.
`timescale 1ns/1ns

module host_model (
  // Clock
  input  wire logic       core_clk,
  // Register access
  output logic      [7:0] reg_addr,
  output logic            reg_rd_stb,
  output logic            reg_wr_stb,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  import accel_regs_pkg::*;

  initial begin
    reg_addr   = 8'h00;
    reg_rd_stb = 1'b0;
    reg_wr_stb = 1'b0;
    reg_wdata  = 8'h00;
  end

  // Byte read; address is scrambled once released
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr   = a;
    reg_rd_stb = 1'b1;
    @(negedge core_clk);
    reg_rd_stb = 1'b0;
    reg_addr   = ~a;
    d          = reg_rdata;
  endtask : rd

  task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr   = a;
    reg_wdata  = d;
    reg_wr_stb = 1'b1;
    @(negedge core_clk);
    reg_wr_stb = 1'b0;
    reg_addr   = ~a;
    reg_wdata  = ~d;
  endtask : wr_raw

  // Control writes always pass through standby first
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a === ADDR_MAIN_CTRL) begin
      wr_raw(a, 8'h00);
    end
    wr_raw(a, d);
  endtask : wr

endmodule : host_model

// File: bench/tb_top.sv
// Self-checking bench for the accelerometer register bank.
// Assumes the host model drives the register strobes; the bench drives the sensing core inputs.
`timescale 1ns/1ns

module tb_top;
  import accel_regs_pkg::*;

  localparam logic [7:0]  ID_SEED = 8'h3c;  // Arbitrary value
  localparam logic [13:0] ZA      = 14'h2a5e;
  localparam logic [13:0] ZB      = 14'h1234;

  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, c;
  logic        reg_rd_stb, reg_wr_stb, irq_pin;
  logic        read_burst_active = 1'b0, sample_strobe = 1'b0, motion_strobe = 1'b0;
  logic        comm_selftest_trigger = 1'b0, irq_unlatched_mode = 1'b0;
  logic [13:0] z_sample_in = 14'h0000;
  logic [5:0]  motion_axis = 6'h00;
  logic        operate_select, resolution_select, sample_ready_irq_enable, motion_wake_enable;
  logic [1:0]  range_select;
  int          err_total = 0;
  int          tests_run = 0;

  always #20 core_clk = ~core_clk;

  host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb),
    .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  accel_output_interrupt_regs #(.SAMPLE_W(14), .ID_VALUE(ID_SEED)) uut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb),
    .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata), .read_burst_active(read_burst_active),
    .reg_rdata(reg_rdata), .z_sample_in(z_sample_in), .sample_strobe(sample_strobe),
    .motion_strobe(motion_strobe), .motion_axis(motion_axis),
    .comm_selftest_trigger(comm_selftest_trigger), .irq_unlatched_mode(irq_unlatched_mode),
    .irq_pin(irq_pin), .operate_select(operate_select), .resolution_select(resolution_select),
    .sample_ready_irq_enable(sample_ready_irq_enable), .range_select(range_select),
    .motion_wake_enable(motion_wake_enable));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask : rdc

  task automatic pin(input logic exp);
    chk({7'h00, irq_pin}, {7'h00, exp});
  endtask : pin

  // New sample, then wait until the bank has taken it
  task automatic smp(input logic [13:0] z);
    @(negedge core_clk);
    z_sample_in   = z;
    sample_strobe = 1'b1;
    @(negedge core_clk);
    sample_strobe = 1'b0;
    z_sample_in   = ~z;
    repeat (2) @(negedge core_clk);
  endtask : smp

  task automatic mot(input logic [5:0] ax);
    @(negedge core_clk);
    motion_axis   = ax;
    motion_strobe = 1'b1;
    @(negedge core_clk);
    motion_strobe = 1'b0;
    motion_axis   = ~ax;
    @(negedge core_clk);
  endtask : mot

  task automatic end_of_test;
    $display("Checks run: %0d, mismatches: %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #2000000;
    err_total++;
    end_of_test;
  end

  initial begin
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    // Reset values, read-only and unmapped places
    rdc(ADDR_MAIN_CTRL, 8'h00);
    rdc(ADDR_SELFTEST_RESP, 8'h55);
    host.wr(ADDR_ID, 8'h00);
    rdc(ADDR_ID, ID_SEED);
    rdc(8'h00, 8'h00);
    host.wr(ADDR_MAIN_CTRL, 8'hff);
    rdc(ADDR_MAIN_CTRL, 8'hfa);
    // Every range code with a fresh sample
    for (int r = 0; r < 4; r++) begin
      c = 8'he2 | (8'(r) << 3);
      host.wr(ADDR_MAIN_CTRL, c);
      chk({operate_select, resolution_select, sample_ready_irq_enable, range_select, 1'b0,
           motion_wake_enable, 1'b0}, c);
      smp(ZA);
      rdc(ADDR_SRC_PRIMARY, 8'h10);
      rdc(ADDR_STATUS, 8'h10);
      pin(1'b1);
      rdc(ADDR_Z_LOW, (r == 3) ? {ZA[5:0], 2'b00} : {ZA[5:2], 4'h0});
      rdc(ADDR_Z_HIGH, ZA[13:6]);
      rdc(ADDR_SRC_PRIMARY, 8'h00);
      rdc(ADDR_STATUS, 8'h00);
      host.rd(ADDR_RELEASE, rv);
      pin(1'b0);
    end
    // Low resolution, ready interrupt disabled
    host.wr(ADDR_MAIN_CTRL, 8'h88);
    smp(ZB);
    rdc(ADDR_Z_LOW, 8'h00);
    rdc(ADDR_SRC_PRIMARY, 8'h10);
    pin(1'b0);
    // Output frozen while a read burst runs
    read_burst_active = 1'b1;
    smp(ZA);
    repeat (2) @(negedge core_clk);
    rdc(ADDR_Z_HIGH, ZB[13:6]);
    read_burst_active = 1'b0;
    repeat (2) @(negedge core_clk);
    rdc(ADDR_Z_HIGH, ZA[13:6]);
    host.rd(ADDR_RELEASE, rv);
    // Standby drops samples and motion, even with wake-up enabled
    host.wr(ADDR_MAIN_CTRL, 8'h02);
    smp(ZB);
    mot(6'h3f);
    rdc(ADDR_SRC_PRIMARY, 8'h00);
    rdc(ADDR_SRC_AXIS, 8'h00);
    // Motion reporting, latched
    host.wr(ADDR_MAIN_CTRL, 8'h82);
    mot(6'h21);
    mot(6'h04);
    rdc(ADDR_SRC_AXIS, 8'h25);
    rdc(ADDR_Z_HIGH, ZA[13:6]);
    rdc(ADDR_SRC_PRIMARY, 8'h02);
    rdc(ADDR_STATUS, 8'h10);
    pin(1'b1);
    rdc(ADDR_RELEASE, 8'h00);
    pin(1'b0);
    rdc(ADDR_SRC_PRIMARY, 8'h00);
    rdc(ADDR_SRC_AXIS, 8'h00);
    // Motion ignored with wake-up disabled
    host.wr(ADDR_MAIN_CTRL, 8'h80);
    mot(6'h3f);
    rdc(ADDR_SRC_AXIS, 8'h00);
    // Communication self-test
    @(negedge core_clk);
    comm_selftest_trigger = 1'b1;
    @(negedge core_clk);
    comm_selftest_trigger = 1'b0;
    rdc(ADDR_SELFTEST_RESP, 8'haa);
    rdc(ADDR_SELFTEST_RESP, 8'h55);
    // Unlatched mode lapses without release
    irq_unlatched_mode = 1'b1;
    host.wr(ADDR_MAIN_CTRL, 8'h82);
    mot(6'h10);
    pin(1'b1);
    rdc(ADDR_SRC_AXIS, 8'h10);
    repeat (760) @(negedge core_clk);
    pin(1'b0);
    rdc(ADDR_SRC_AXIS, 8'h00);
    end_of_test;
  end

endmodule : tb_top
